// ==== verilog/sdr_pkg.sv ====
// Purpose: Constants for the speed-detect / reverse-drive setup registers
// Assumes: Plain register port, 100 MHz clock
// Notes: Offsets are byte addresses on the register port
`default_nettype none
package sdr_pkg;
    // ========================================================
    // Addresses
    localparam logic [7:0] SDR_ADDR_ISD = 8'h80;
    localparam logic [7:0] SDR_ADDR_REV = 8'h82;
    localparam logic [31:0] SDR_RESET_VAL = 32'h0000_0000;
    localparam logic [31:0] SDR_ZERO = 32'h0000_0000;
    // ========================================================
    // Initial-speed-detect fields
    localparam int SDR_COAST_LSB = 9;
    localparam int SDR_COAST_W = 4;
    localparam int SDR_EMF_LSB = 6;
    localparam int SDR_EMF_W = 3;
    localparam int SDR_HANDOFF_LSB = 2;
    localparam int SDR_HANDOFF_W = 4;
    localparam int SDR_CURCAP_LSB = 0;
    localparam int SDR_CURCAP_W = 2;
    // ========================================================
    // Reverse-drive fields
    localparam int SDR_PARITY_BIT = 31;
    localparam int SDR_A1_LSB = 27;
    localparam int SDR_A1_W = 4;
    localparam int SDR_A2_LSB = 23;
    localparam int SDR_A2_W = 4;
    localparam int SDR_BCUR_LSB = 20;
    localparam int SDR_BCUR_W = 3;
    localparam int SDR_KP_LSB = 10;
    localparam int SDR_KP_W = 10;
    localparam int SDR_KI_LSB = 0;
    localparam int SDR_KI_W = 10;
    // ========================================================
    // Coast duration per code, in ms (x1000 for 7.5 s handled as 7500)
    localparam int SDR_COAST_MS [16] = '{10, 50, 100, 200, 300, 400, 500,
        750, 1000, 2000, 3000, 4000, 5000, 7500, 10000, 15000};
    // Standstill level per code, mV
    localparam int SDR_EMF_MV [8] = '{50, 75, 100, 250, 500, 750, 1000,
        1500};
    // Handoff level per code, tenths of a percent of max speed
    localparam int SDR_HANDOFF_PM [16] = '{25, 50, 75, 100, 125, 150,
        200, 250, 300, 400, 500, 600, 700, 800, 900, 1000};
    // Current cap per code, mA
    localparam int SDR_CURCAP_MA [4] = '{1500, 2500, 3500, 5000};
    localparam int SDR_CLK_MHZ = 100;
endpackage
`default_nettype wire

// ==== verilog/sdr_cfg.sv ====
// Purpose: Register bank for speed detect and reverse drive setup
// Assumes: Synchronous active-high reset, one clock
// Notes: Decoded levels are presented for the control core
`default_nettype none
module sdr_cfg
    import sdr_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic [31:0] isd_word_o,
    output logic [31:0] rev_word_o,
    output logic [15:0] coast_ms_o,
    output logic [10:0] standstill_mv_o,
    output logic [9:0] handoff_pm_o,
    output logic [12:0] current_cap_ma_o,
    output logic parity_o,
    output logic [3:0] accel_one_o,
    output logic [3:0] accel_two_o,
    output logic [2:0] brake_current_o,
    output logic [9:0] brake_kp_o,
    output logic [9:0] brake_ki_o
);
    // ========================================================
    // Storage
    logic [31:0] isd_reg, isd_next, rev_reg, rev_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [15:0] coast_reg, coast_next;
    logic [10:0] emf_reg, emf_next;
    logic [9:0] hand_reg, hand_next;
    logic [12:0] cap_reg, cap_next;
    logic [SDR_COAST_W-1:0] coast_code;
    logic [SDR_EMF_W-1:0] emf_code;
    logic [SDR_HANDOFF_W-1:0] hand_code;
    logic [SDR_CURCAP_W-1:0] cap_code;

    // Write and readback path, full word stored so readback is exact
    always_comb begin
        isd_next = isd_reg;
        rev_next = rev_reg;
        rdata_next = SDR_ZERO;
        if (wr_i && addr_i == SDR_ADDR_ISD) begin
            isd_next = wdata_i;
        end
        if (wr_i && addr_i == SDR_ADDR_REV) begin
            rev_next = wdata_i;
        end
        if (rd_i) begin
            case (addr_i)
                SDR_ADDR_ISD: rdata_next = isd_reg;
                SDR_ADDR_REV: rdata_next = rev_reg;
                default: rdata_next = SDR_ZERO; // Unmapped reads zero
            endcase
        end
    end

    // Decode codes into physical levels, from the next word so that
    // the decoded outputs line up with the stored word
    always_comb begin
        coast_code = isd_next[SDR_COAST_LSB +: SDR_COAST_W];
        emf_code = isd_next[SDR_EMF_LSB +: SDR_EMF_W];
        hand_code = isd_next[SDR_HANDOFF_LSB +: SDR_HANDOFF_W];
        cap_code = isd_next[SDR_CURCAP_LSB +: SDR_CURCAP_W];
        coast_next = 16'(SDR_COAST_MS[coast_code]);
        emf_next = 11'(SDR_EMF_MV[emf_code]);
        hand_next = 10'(SDR_HANDOFF_PM[hand_code]);
        cap_next = 13'(SDR_CURCAP_MA[cap_code]);
    end

    // Registers
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            isd_reg <= SDR_RESET_VAL;
            rev_reg <= SDR_RESET_VAL;
            rdata_reg <= SDR_ZERO;
            coast_reg <= 16'(SDR_COAST_MS[0]);
            emf_reg <= 11'(SDR_EMF_MV[0]);
            hand_reg <= 10'(SDR_HANDOFF_PM[0]);
            cap_reg <= 13'(SDR_CURCAP_MA[0]);
        end else begin
            isd_reg <= isd_next;
            rev_reg <= rev_next;
            rdata_reg <= rdata_next;
            coast_reg <= coast_next;
            emf_reg <= emf_next;
            hand_reg <= hand_next;
            cap_reg <= cap_next;
        end
    end

    // ========================================================
    // Outputs, all straight from flip-flops
    assign rdata_o = rdata_reg;
    assign isd_word_o = isd_reg;
    assign rev_word_o = rev_reg;
    assign coast_ms_o = coast_reg;
    assign standstill_mv_o = emf_reg;
    assign handoff_pm_o = hand_reg;
    assign current_cap_ma_o = cap_reg;
    assign parity_o = rev_reg[SDR_PARITY_BIT];
    assign accel_one_o = rev_reg[SDR_A1_LSB +: SDR_A1_W];
    assign accel_two_o = rev_reg[SDR_A2_LSB +: SDR_A2_W];
    assign brake_current_o = rev_reg[SDR_BCUR_LSB +: SDR_BCUR_W];
    assign brake_kp_o = rev_reg[SDR_KP_LSB +: SDR_KP_W];
    assign brake_ki_o = rev_reg[SDR_KI_LSB +: SDR_KI_W];

    // ========================================================
    // Checks
    sequence s_wr_rev;
        wr_i && addr_i == SDR_ADDR_REV;
    endsequence
    sequence s_rd_rev;
        rd_i && addr_i == SDR_ADDR_REV;
    endsequence
    sequence s_wr_isd;
        wr_i && addr_i == SDR_ADDR_ISD;
    endsequence
    sequence s_rd_isd;
        rd_i && addr_i == SDR_ADDR_ISD;
    endsequence

    // Only the edge right after release; the very first edge sees X
    property p_rev_reset;
        @(posedge clock_i) (!rst_i && $past(rst_i))
            |-> rev_word_o == SDR_ZERO;
    endproperty
    a_rev_reset: assert property (p_rev_reset)
        else $error("reverse word not zero after reset");

    property p_rev_readback;
        @(posedge clock_i) disable iff (rst_i)
        (s_wr_rev ##1 (s_rd_rev and !wr_i)) |=> rdata_o == $past(wdata_i, 2);
    endproperty
    a_rev_readback: assert property (p_rev_readback)
        else $error("reverse word readback mismatch");

    // Readback against what was written, not against the stored copy
    property p_isd_readback;
        @(posedge clock_i) disable iff (rst_i)
        (s_wr_isd ##1 !wr_i ##1 s_rd_isd) |=> rdata_o == $past(wdata_i, 3);
    endproperty
    a_isd_readback: assert property (p_isd_readback)
        else $error("setup word readback mismatch");

    // Read data is zero whenever no read was taken the cycle before
    property p_rd_idle;
        @(posedge clock_i) disable iff (rst_i)
        !rd_i |=> rdata_o == SDR_ZERO;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero when idle");

    // Unmapped writes must leave both words alone
    property p_unmapped_wr;
        @(posedge clock_i) disable iff (rst_i)
        (wr_i && addr_i != SDR_ADDR_ISD && addr_i != SDR_ADDR_REV)
            |=> rev_word_o == $past(rev_word_o)
            && isd_word_o == $past(isd_word_o);
    endproperty
    a_unmapped_wr: assert property (p_unmapped_wr)
        else $error("unmapped write changed a word");

    // Decoded levels fall back to the code-0 values on reset
    property p_decode_reset;
        @(posedge clock_i) (!rst_i && $past(rst_i)) |->
            coast_ms_o == 16'h000A && standstill_mv_o == 11'h032
            && handoff_pm_o == 10'h019 && current_cap_ma_o == 13'h05DC;
    endproperty
    a_decode_reset: assert property (p_decode_reset)
        else $error("decoded levels wrong after reset");

    property p_isd_store;
        @(posedge clock_i) disable iff (rst_i)
        (wr_i && addr_i == SDR_ADDR_ISD) |=> isd_word_o == $past(wdata_i);
    endproperty
    a_isd_store: assert property (p_isd_store)
        else $error("setup word not stored");

    property p_rev_fields;
        @(posedge clock_i) disable iff (rst_i)
        s_wr_rev |=> accel_one_o == $past(wdata_i[30:27])
            && brake_ki_o == $past(wdata_i[9:0])
            && parity_o == $past(wdata_i[31]);
    endproperty
    a_rev_fields: assert property (p_rev_fields)
        else $error("reverse field placement wrong");

    property p_rev_mid_fields;
        @(posedge clock_i) disable iff (rst_i)
        s_wr_rev |=> accel_two_o == $past(wdata_i[26:23])
            && brake_current_o == $past(wdata_i[22:20])
            && brake_kp_o == $past(wdata_i[19:10]);
    endproperty
    a_rev_mid_fields: assert property (p_rev_mid_fields)
        else $error("reverse middle fields placed wrong");

    property p_coast;
        @(posedge clock_i) disable iff (rst_i)
        (wr_i && addr_i == SDR_ADDR_ISD && wdata_i[12:9] == 4'hF)
            |=> coast_ms_o == 16'h3A98;
    endproperty
    a_coast: assert property (p_coast)
        else $error("coast duration decode wrong");

    property p_emf;
        @(posedge clock_i) disable iff (rst_i)
        (wr_i && addr_i == SDR_ADDR_ISD && wdata_i[8:6] == 3'h3)
            |=> standstill_mv_o == 11'h0FA;
    endproperty
    a_emf: assert property (p_emf)
        else $error("standstill level decode wrong");

    property p_hand;
        @(posedge clock_i) disable iff (rst_i)
        (wr_i && addr_i == SDR_ADDR_ISD && wdata_i[5:2] == 4'h6)
            |=> handoff_pm_o == 10'h0C8;
    endproperty
    a_hand: assert property (p_hand)
        else $error("handoff level decode wrong");

    property p_cap;
        @(posedge clock_i) disable iff (rst_i)
        (wr_i && addr_i == SDR_ADDR_ISD && wdata_i[1:0] == 2'h3)
            |=> current_cap_ma_o == 13'h1388;
    endproperty
    a_cap: assert property (p_cap)
        else $error("current cap decode wrong");
endmodule
`default_nettype wire

// ==== testbench/tb_sdr_cfg.sv ====
// Purpose: Self-checking bench for the setup register bank
// Assumes: Strobes driven by NBA right after rising edges
// Notes: Decode tables live here, apart from the design
`default_nettype none
module tb_sdr_cfg
    import sdr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0000_0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o, isd_word_o, rev_word_o;
    logic [15:0] coast_ms_o;
    logic [10:0] standstill_mv_o;
    logic [9:0] handoff_pm_o, brake_kp_o, brake_ki_o;
    logic [12:0] current_cap_ma_o;
    logic parity_o;
    logic [3:0] accel_one_o, accel_two_o;
    logic [2:0] brake_current_o;
    int n_errors = 0;
    int checks_done = 0;
    // Decoded levels: ms, mV, tenths of percent, mA
    int ms_tab [16] = '{10, 50, 100, 200, 300, 400, 500, 750, 1000, 2000,
        3000, 4000, 5000, 7500, 10000, 15000};
    int mv_tab [8] = '{50, 75, 100, 250, 500, 750, 1000, 1500};
    int pm_tab [16] = '{25, 50, 75, 100, 125, 150, 200, 250, 300, 400,
        500, 600, 700, 800, 900, 1000};
    int ma_tab [4] = '{1500, 2500, 3500, 5000};

    // ========================================================
    // Clock, design and watchdog
    always #5 clock_i = ~clock_i;
    sdr_cfg u_sdr_cfg (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .isd_word_o(isd_word_o), .rev_word_o(rev_word_o),
        .coast_ms_o(coast_ms_o), .standstill_mv_o(standstill_mv_o),
        .handoff_pm_o(handoff_pm_o), .current_cap_ma_o(current_cap_ma_o),
        .parity_o(parity_o), .accel_one_o(accel_one_o),
        .accel_two_o(accel_two_o), .brake_current_o(brake_current_o),
        .brake_kp_o(brake_kp_o), .brake_ki_o(brake_ki_o));
    // Run needs about 130 cycles; 5000 leaves ample margin
    initial begin
        #50000;
        n_errors++;
        finish_test();
    end

    // ========================================================
    // Bus and compare tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got=%08h exp=%08h", $time, got, exp);
        end
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
        #1;
    endtask
    // Read data stands one cycle, then must fall back to zero
    task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, e);
        @(posedge clock_i);
        #1 chk(rdata_o, 32'h0000_0000);
    endtask

    // ========================================================
    // Scenarios
    task automatic t_reset();
        chk(rev_word_o, 32'h0000_0000);
        chk(isd_word_o, 32'h0000_0000);
        chk(coast_ms_o, 32'(ms_tab[0]));
        chk(standstill_mv_o, 32'(mv_tab[0]));
        chk(handoff_pm_o, 32'(pm_tab[0]));
        chk(current_cap_ma_o, 32'(ma_tab[0]));
        bus_rd(SDR_ADDR_REV, 32'h0000_0000);
    endtask
    // Every code of every setup field, upper bits kept too
    task automatic t_isd_codes();
        logic [31:0] w;
        logic [3:0] c;
        for (int i = 0; i < 16; i++) begin
            c = i[3:0];
            w = {19'h2D2D3, c, c[2:0], ~c, c[1:0]};
            bus_wr(SDR_ADDR_ISD, w);
            chk(isd_word_o, w);
            chk(coast_ms_o, 32'(ms_tab[c]));
            chk(standstill_mv_o, 32'(mv_tab[c[2:0]]));
            chk(handoff_pm_o, 32'(pm_tab[~c]));
            chk(current_cap_ma_o, 32'(ma_tab[c[1:0]]));
            bus_rd(SDR_ADDR_ISD, w);
        end
    endtask
    // Pattern and its inverse through each reverse field
    task automatic t_rev(input logic [31:0] w);
        bus_wr(SDR_ADDR_REV, w);
        chk(rev_word_o, w);
        chk({parity_o, accel_one_o, accel_two_o}, w[31:23]);
        chk(brake_current_o, w[22:20]);
        chk({brake_kp_o, brake_ki_o}, w[19:0]);
        bus_rd(SDR_ADDR_REV, w);
    endtask
    // Unmapped places are ignored; then write and read back to back
    task automatic t_unmapped();
        bus_wr(8'h84, 32'hFFFF_FFFF);
        chk(rev_word_o, 32'hAAAA_AAAA);
        bus_rd(8'h83, 32'h0000_0000);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= SDR_ADDR_REV;
        wdata_i <= 32'h1234_5678;
        @(posedge clock_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, 32'h1234_5678);
        @(posedge clock_i);
        rst_i <= 1'b1;
        @(posedge clock_i);
        rst_i <= 1'b0;
        #1 chk(rev_word_o, 32'h0000_0000);
        chk(isd_word_o, 32'h0000_0000);
        chk(coast_ms_o, 32'(ms_tab[0]));
        chk(current_cap_ma_o, 32'(ma_tab[0]));
        bus_rd(SDR_ADDR_ISD, 32'h0000_0000);
    endtask

    task automatic finish_test();
        if (n_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        #1 t_reset();
        t_isd_codes();
        t_rev(32'hD5AA_AD54);
        t_rev(32'h2A55_52AB);
        t_rev(32'hAAAA_AAAA);
        t_unmapped();
        finish_test();
    end
endmodule
`default_nettype wire
